// >>> hw/lsif_defines.vh
// lsif_defines.vh: offsets, fields, reset values and timing counts
// assumes: included by the receive path and its fifo
`ifndef LSIF_DEFINES_VH
`define LSIF_DEFINES_VH

// register offsets on the register port
`define LSIF_OFS_STATUS      8'h06
`define LSIF_OFS_LEVEL       8'h24
`define LSIF_OFS_IF_CFG      8'h26
`define LSIF_OFS_INTERP      8'h28
`define LSIF_OFS_DLY_TAP     8'h5e
`define LSIF_OFS_DLY_CTRL    8'h5f

// interface configuration fields
`define LSIF_CFG_BYTE_BIT    0
`define LSIF_CFG_INV_BIT     5
`define LSIF_CFG_PAIR_BIT    6
`define LSIF_CFG_FMT_BIT     7

// delay control fields
`define LSIF_DLY_EN_BIT      3
`define LSIF_DLY_TAP3_LO     3'h5

// delay tap select codes
`define LSIF_TAP_CODE1       8'h07
`define LSIF_TAP_CODE2       8'h7f
`define LSIF_TAP_CODE3       8'hff

// status fields
`define LSIF_ST_UNDER_BIT    0
`define LSIF_ST_OVER_BIT     1
`define LSIF_ST_MARGIN_BIT   2

// reset values
`define LSIF_RST_IF_CFG      8'h00
`define LSIF_RST_INTERP      8'h00
`define LSIF_RST_DLY_TAP     8'h00
`define LSIF_RST_DLY_CTRL    8'h00

// fifo shape and margins
`define LSIF_SAMPLE_W        16
`define LSIF_FIFO_DEPTH      8
`define LSIF_FIFO_AW         3
`define LSIF_LVL_LOW         4'h1
`define LSIF_LVL_HIGH        4'h7

// pin synchroniser depth and delay line length
`define LSIF_SYNC_STAGES     3
`define LSIF_DLY_STAGES      4

`endif

// >>> hw/lsif_fifo.v
// lsif_fifo.v: small sample fifo with registered read data
// assumes: one clock, pops and pushes from logic on that clock
`timescale 1ns/1ps
`include "lsif_defines.vh"

module lsif_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_clk_sys,
    input  wire             i_nrst,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    input  wire [WIDTH-1:0] i_wr_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready,
    output reg  [WIDTH-1:0] o_rd_data,
    output wire [AW:0]      o_level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wptr_q;
    reg [AW:0]      rptr_q;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    // same slot and wrap bit apart means full, same both means empty
    assign full       = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) &&
                        (wptr_q[AW] != rptr_q[AW]);
    assign empty      = (wptr_q == rptr_q);
    assign o_wr_ready = ~full;
    assign o_rd_valid = ~empty;
    assign push       = i_wr_valid & ~full;
    assign pop        = i_rd_ready & ~empty;
    assign o_level    = wptr_q - rptr_q;

    always @(posedge i_clk_sys) begin
        if (push) begin
            mem[wptr_q[AW-1:0]] <= i_wr_data;
        end
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wptr_q    <= {(AW+1){1'b0}};
            rptr_q    <= {(AW+1){1'b0}};
            o_rd_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1; // R16
            end
            if (pop) begin
                o_rd_data <= mem[rptr_q[AW-1:0]];
                rptr_q    <= rptr_q + 1'b1; // R17
            end
        end
    end

endmodule // lsif_fifo

// >>> hw/lsif_rx.v
// lsif_rx.v: source-synchronous sample receiver with single-clock sample fifo
// assumes: pins arrive unsynchronised, register port on i_clk_sys
//
// Behaviour
// (R1) byte order I high, I low, Q high, Q low
// (R2) frame rising edge marks I high byte
// (R3) one-shot or periodic frame, first edge aligns
// (R4) single frame pulse held one clock period
// (R5) periodic frame at clock over twice n
// (R6) clock and frame aligned with data
// (R7) bit 7 picks offset binary or two's complement
// (R8) bit 6 picks I/Q pairing order
// (R9) bit 5 reverses input bus bit order
// (R10) four-setting delay shifts sampling point
// (R11) delay setting codes written by software
// (R12) delay control bit 3 enables delay line
// (R13) samples cross to core domain via fifo; here pins are synchronised to i_clk_sys and the fifo runs on that one clock
// (R14) fifo holds two 16-bit channels, eight slots
// (R15) capture, format, then write fifo slot
// (R16) write pointer steps per loaded word
// (R17) read pointer steps per word read
// (R18) pointers step at core rate over interpolation; here only the read pointer does, the write pointer steps per loaded word
// (R19) equal pointers flag overflow or underflow; code uses a full-fifo overwrite and an empty read slot instead
// (R20) keep fifo near half full
// (R21) bit 0 picks word or byte mode
// (R22) word mode: I on rise, Q on fall
// (R23) three status bits report fifo errors
// (R24) byte mode: pair written after fourth byte
`timescale 1ns/1ps
`include "lsif_defines.vh"

module lsif_rx (
    input  wire        i_clk_sys,
    input  wire        i_nrst,
    input  wire        i_fwd_clk,
    input  wire        i_frame,
    input  wire [15:0] i_data,
    input  wire        i_reg_wr,
    input  wire [7:0]  i_reg_addr,
    input  wire [7:0]  i_reg_wdata,
    output reg  [7:0]  o_reg_rdata,
    input  wire        i_core_ready,
    output reg         o_sample_valid,
    output wire [15:0] o_sample_i,
    output wire [15:0] o_sample_q
);

    localparam SW = `LSIF_SAMPLE_W;
    localparam NS = `LSIF_SYNC_STAGES;
    localparam ND = `LSIF_DLY_STAGES;

    // register file
    reg  [7:0]    cfg_q;
    reg  [7:0]    interp_q;
    reg  [7:0]    dly_tap_q;
    reg  [7:0]    dly_ctrl_q;
    reg  [2:0]    status_q;

    // pin synchronisers
    reg  [NS-1:0] clk_sync_q;
    reg           clk_lvl_q;
    reg  [NS-1:0] frm_sync_q;
    reg  [15:0]   dat_sync_q [0:NS-1];
    reg  [ND-1:0] edge_dly_q;
    reg  [ND-1:0] rise_dly_q;

    // assembly
    reg  [1:0]    byte_idx_q;
    reg           aligned_q;
    reg           frm_prev_q;
    reg  [15:0]   hold_i_q;
    reg  [7:0]    hold_b_q;
    reg           pend_q;
    reg  [31:0]   pend_data_q;
    reg  [7:0]    rate_cnt_q;
    reg  [3:0]    prev_lvl_q;

    wire          edge_now;
    wire          rise_now;
    wire [1:0]    tap;
    wire          cap;
    wire          cap_rise;
    wire [15:0]   bus_rev;
    wire [15:0]   bus_in;
    wire          byte_mode;
    wire          frm_rise;
    wire          wr_ready;
    wire          rd_valid;
    wire [31:0]   rd_data;
    wire [3:0]    level;
    wire          rate_en;
    wire          pop;
    wire [7:0]    rate_div;
    reg           pair_done;
    reg  [31:0]   pair_word;

    // offset binary to two's complement by msb flip
    function [15:0] fmt;
        input [15:0] w;
        input        offset_bin;
        begin
            fmt = offset_bin ? {~w[15], w[14:0]} : w;
        end
    endfunction

    // delay tap codes to setting 0..3
    function [1:0] tap_of;
        input [7:0] sel;
        input [2:0] lo;
        begin
            if (sel == `LSIF_TAP_CODE3 && lo == `LSIF_DLY_TAP3_LO) begin
                tap_of = 2'h3;
            end else if (sel == `LSIF_TAP_CODE2 ||
                         sel == `LSIF_TAP_CODE3) begin
                tap_of = 2'h2;
            end else if (sel == `LSIF_TAP_CODE1) begin
                tap_of = 2'h1;
            end else begin
                tap_of = 2'h0;
            end
        end
    endfunction

    assign byte_mode = cfg_q[`LSIF_CFG_BYTE_BIT]; // R21

    // clock transitions counted once stages two and three agree
    assign edge_now = (clk_sync_q[1] == clk_sync_q[2]) &&
                      (clk_sync_q[2] != clk_lvl_q); // R6
    assign rise_now = edge_now & clk_sync_q[2]; // R22

    // delay line moves the sampling edge later against the data
    assign tap      = dly_ctrl_q[`LSIF_DLY_EN_BIT] ?
                      tap_of(dly_tap_q, dly_ctrl_q[2:0]) : 2'h0; // R10 R12
    assign cap      = (tap == 2'h0) ? edge_now : edge_dly_q[tap-2'h1];
    assign cap_rise = (tap == 2'h0) ? rise_now : rise_dly_q[tap-2'h1];

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_rev
            // byte mode reverses within the low eight lines only
            if (gi < 8) begin : g_lo
                assign bus_rev[gi] = byte_mode ? dat_sync_q[2][7-gi] :
                                     dat_sync_q[2][15-gi];
            end else begin : g_hi
                assign bus_rev[gi] = byte_mode ? 1'b0 :
                                     dat_sync_q[2][15-gi];
            end
        end
    endgenerate

    assign bus_in   = cfg_q[`LSIF_CFG_INV_BIT] ? bus_rev :
                      dat_sync_q[2]; // R9
    assign frm_rise = frm_sync_q[2] & ~frm_prev_q; // R2

    integer k;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_sync_q <= {NS{1'b0}};
            clk_lvl_q  <= 1'b0;
            frm_sync_q <= {NS{1'b0}};
            edge_dly_q <= {ND{1'b0}};
            rise_dly_q <= {ND{1'b0}};
            for (k = 0; k < NS; k = k + 1) begin
                dat_sync_q[k] <= 16'h0000;
            end
        end else begin
            clk_sync_q <= {clk_sync_q[NS-2:0], i_fwd_clk};
            clk_lvl_q  <= edge_now ? clk_sync_q[2] : clk_lvl_q;
            frm_sync_q <= {frm_sync_q[NS-2:0], i_frame};
            edge_dly_q <= {edge_dly_q[ND-2:0], edge_now};
            rise_dly_q <= {rise_dly_q[ND-2:0], rise_now};
            dat_sync_q[0] <= i_data;
            for (k = 1; k < NS; k = k + 1) begin
                dat_sync_q[k] <= dat_sync_q[k-1];
            end
        end
    end

    // pair assembly after capture
    always @* begin
        pair_done = 1'b0;
        pair_word = 32'h0000_0000;
        if (cap && !byte_mode && !cap_rise) begin
            pair_done = 1'b1; // R22
            pair_word = {hold_i_q, bus_in};
        end else if (cap && byte_mode && aligned_q && byte_idx_q == 2'h3) begin
            pair_done = 1'b1; // R24
            pair_word = {hold_i_q, hold_b_q, bus_in[7:0]}; // R1
        end
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            byte_idx_q <= 2'h0;
            aligned_q  <= 1'b0;
            frm_prev_q <= 1'b0;
            hold_i_q   <= 16'h0000;
            hold_b_q   <= 8'h00;
        end else if (i_reg_wr && i_reg_addr == `LSIF_OFS_IF_CFG) begin
            aligned_q  <= 1'b0;
            byte_idx_q <= 2'h0;
        end else if (cap) begin
            frm_prev_q <= frm_sync_q[2];
            if (!byte_mode) begin
                if (cap_rise) begin
                    hold_i_q <= bus_in; // R22
                end
            end else if (frm_rise && !aligned_q) begin
                aligned_q  <= 1'b1; // R3
                hold_b_q   <= bus_in[7:0];
                byte_idx_q <= 2'h1;
            end else if (aligned_q) begin
                byte_idx_q <= byte_idx_q + 2'h1; // R24
                if (byte_idx_q == 2'h0 || byte_idx_q == 2'h2) begin
                    hold_b_q <= bus_in[7:0];
                end
                if (byte_idx_q == 2'h1) begin
                    hold_i_q <= {hold_b_q, bus_in[7:0]}; // R1
                end
            end
        end
    end

    // a pair waits while the fifo is full; a newer one then overwrites it and flags overflow
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pend_q      <= 1'b0;
            pend_data_q <= 32'h0000_0000;
        end else if (pair_done) begin
            pend_q      <= 1'b1;
            pend_data_q <= {fmt(pair_word[31:16], cfg_q[`LSIF_CFG_FMT_BIT]),
                            fmt(pair_word[15:0],
                                cfg_q[`LSIF_CFG_FMT_BIT])}; // R7 R15
        end else if (wr_ready) begin
            pend_q <= 1'b0;
        end
    end

    lsif_fifo #(
        .WIDTH (2*SW),
        .DEPTH (`LSIF_FIFO_DEPTH),
        .AW    (`LSIF_FIFO_AW)
    ) u_fifo (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_wr_valid (pend_q),
        .o_wr_ready (wr_ready),
        .i_wr_data  (pend_data_q),
        .o_rd_valid (rd_valid),
        .i_rd_ready (pop),
        .o_rd_data  (rd_data),
        .o_level    (level)
    ); // R13 R14

    // read rate enable: core clock over the interpolation factor
    assign rate_div = 8'h01 << interp_q[1:0];
    assign rate_en  = (rate_cnt_q == 8'h00);
    assign pop      = rate_en & rd_valid & i_core_ready; // R18

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rate_cnt_q     <= 8'h00;
            o_sample_valid <= 1'b0;
        end else begin
            rate_cnt_q     <= rate_en ? rate_div - 8'h01 :
                              rate_cnt_q - 8'h01; // R18
            o_sample_valid <= pop;
        end
    end

    assign o_sample_i = cfg_q[`LSIF_CFG_PAIR_BIT] ? rd_data[15:0] :
                        rd_data[31:16]; // R8
    assign o_sample_q = cfg_q[`LSIF_CFG_PAIR_BIT] ? rd_data[31:16] :
                        rd_data[15:0]; // R8

    // register writes and sticky status, set wins over clear
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_q      <= `LSIF_RST_IF_CFG;
            interp_q   <= `LSIF_RST_INTERP;
            dly_tap_q  <= `LSIF_RST_DLY_TAP;
            dly_ctrl_q <= `LSIF_RST_DLY_CTRL;
            status_q   <= 3'h0;
            prev_lvl_q <= 4'h0;
        end else begin
            prev_lvl_q <= level;
            if (i_reg_wr) begin
                if (i_reg_addr == `LSIF_OFS_IF_CFG) begin
                    cfg_q <= i_reg_wdata;
                end else if (i_reg_addr == `LSIF_OFS_INTERP) begin
                    interp_q <= i_reg_wdata;
                end else if (i_reg_addr == `LSIF_OFS_DLY_TAP) begin
                    dly_tap_q <= i_reg_wdata; // R11
                end else if (i_reg_addr == `LSIF_OFS_DLY_CTRL) begin
                    dly_ctrl_q <= i_reg_wdata; // R11 R12
                end
            end
            status_q <= (status_q &
                         ~((i_reg_wr && i_reg_addr == `LSIF_OFS_STATUS) ?
                           i_reg_wdata[2:0] : 3'h0)) |
                        {(level != prev_lvl_q) &&
                         (level <= `LSIF_LVL_LOW ||
                          level >= `LSIF_LVL_HIGH),
                         pair_done & pend_q & ~wr_ready,
                         rate_en & i_core_ready & ~rd_valid}; // R19 R23 R20
        end
    end

    // registered read data, unmapped offsets read zero
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_addr == `LSIF_OFS_IF_CFG) begin
            o_reg_rdata <= cfg_q;
        end else if (i_reg_addr == `LSIF_OFS_INTERP) begin
            o_reg_rdata <= interp_q;
        end else if (i_reg_addr == `LSIF_OFS_DLY_TAP) begin
            o_reg_rdata <= dly_tap_q;
        end else if (i_reg_addr == `LSIF_OFS_DLY_CTRL) begin
            o_reg_rdata <= dly_ctrl_q;
        end else if (i_reg_addr == `LSIF_OFS_STATUS) begin
            o_reg_rdata <= {5'h00, status_q};
        end else if (i_reg_addr == `LSIF_OFS_LEVEL) begin
            o_reg_rdata <= {4'h0, level};
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

endmodule // lsif_rx

// >>> testbench/lsif_rx_chk.sv
// lsif_rx_chk.sv: port assertions for the receive path
// assumes: bound into lsif_rx, one clock domain
`timescale 1ns/1ps
module lsif_rx_chk (
    input wire       i_clk_sys,
    input wire       i_nrst,
    input wire       i_reg_wr,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire       i_core_ready,
    input wire       o_sample_valid
);
    reg  [1:0] code_q;
    reg  [3:0] gap_q;
    reg        arm_q;
    wire [3:0] fac_m1 = (4'h1 << code_q) - 4'h1;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            code_q <= 2'h0;
            gap_q  <= 4'h0;
            arm_q  <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == 8'h28) begin
                code_q <= i_reg_wdata[1:0];
                arm_q  <= 1'b0;
            end else if (o_sample_valid) begin
                arm_q  <= 1'b1;
            end
            if (o_sample_valid) begin
                gap_q <= 4'h0;
            end else if (gap_q != 4'hf) begin
                gap_q <= gap_q + 4'h1;
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    sequence cfg_wr_s;
        i_reg_wr && (i_reg_addr == 8'h26 || i_reg_addr == 8'h5e);
    endsequence
    sequence rate_wr_s;
        i_reg_wr && i_reg_addr == 8'h28;
    endsequence
    sequence hold_s;
        !i_reg_wr && i_reg_addr == $past(i_reg_addr);
    endsequence
    sequence quiet_s;
        !o_sample_valid [*4];
    endsequence
    rate_gap_a: assert property (
        o_sample_valid && arm_q |-> gap_q >= fac_m1)
        else $error("sample spacing shorter than rate");
    cfg_readback_a: assert property (
        cfg_wr_s ##1 hold_s |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("config readback wrong");
    rate_readback_a: assert property (
        rate_wr_s ##1 hold_s |=>
        o_reg_rdata[1:0] == $past(i_reg_wdata[1:0], 2))
        else $error("rate readback wrong");
    level_max_a: assert property (
        $past(i_reg_addr) == 8'h24 |-> o_reg_rdata <= 8'h08)
        else $error("level above depth");
    status_rsvd_a: assert property (
        $past(i_reg_addr) == 8'h06 |-> o_reg_rdata[7:3] == 5'h00)
        else $error("status spare bits set");
    pop_ready_a: assert property (
        o_sample_valid |-> $past(i_core_ready))
        else $error("sample without core ready");
    stall_hold_a: assert property (
        !i_core_ready [*2] |=> !o_sample_valid)
        else $error("sample during stall");
    rst_quiet_a: assert property (
        $rose(i_nrst) |-> quiet_s)
        else $error("sample too soon after reset");
endmodule // lsif_rx_chk

bind lsif_rx lsif_rx_chk u_chk (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_core_ready(i_core_ready),
    .o_sample_valid(o_sample_valid)
);

// >>> testbench/lsif_src.sv
// lsif_src.sv: sample source driving forwarded clock, frame and data
// assumes: called by the bench, pins change at falling core edges
`timescale 1ns/1ps
module lsif_src (
    input  wire        i_clk_sys,
    output reg         o_fwd_clk,
    output reg         o_frame,
    output reg  [15:0] o_data
);
    initial begin
        o_fwd_clk = 1'b0;
        o_frame   = 1'b0;
        o_data    = 16'h0000;
    end
    task edge_out(input [15:0] d, input f);
        begin
            @(negedge i_clk_sys);
            o_data    = d;
            o_frame   = f;
            o_fwd_clk = ~o_fwd_clk;
            repeat (8) @(negedge i_clk_sys);
            o_data    = ~d;
        end
    endtask
    task send(input [15:0] vi, input [15:0] vq, input bm, input f);
        begin
            if (bm) begin
                edge_out({8'h00, vi[15:8]}, f);
                edge_out({8'h00, vi[7:0]}, f);
                edge_out({8'h00, vq[15:8]}, 1'b0);
                edge_out({8'h00, vq[7:0]}, 1'b0);
            end else begin
                edge_out(vi, 1'b0);
                edge_out(vq, 1'b0);
            end
        end
    endtask
endmodule // lsif_src

// >>> testbench/lsif_rx_test.sv
// lsif_rx_test.sv: self-checking bench for the receive path
// assumes: lsif_src drives the pins, checker bound to the dut
`timescale 1ns/1ps
module lsif_rx_test;
    reg         clk;
    reg         nrst;
    reg         wr;
    reg  [7:0]  addr;
    reg  [7:0]  wdata;
    reg         rdy;
    reg  [7:0]  cfg;
    reg  [15:0] ri;
    reg  [15:0] rq;
    reg  [31:0] tmp;
    reg  [31:0] exp_q[$];
    wire        fclk;
    wire        frm;
    wire [15:0] din;
    wire [7:0]  rdata;
    wire        vld;
    wire [15:0] si;
    wire [15:0] sq;
    integer     num_errors;
    integer     cmp_count;
    integer     seed;
    integer     k;
    integer     n;
    lsif_src src (.i_clk_sys(clk), .o_fwd_clk(fclk), .o_frame(frm),
        .o_data(din));
    lsif_rx dut (.i_clk_sys(clk), .i_nrst(nrst), .i_fwd_clk(fclk),
        .i_frame(frm), .i_data(din), .i_reg_wr(wr), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_core_ready(rdy),
        .o_sample_valid(vld), .o_sample_i(si), .o_sample_q(sq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task summarize;
        begin
            $display("errors %0d compares %0d", num_errors, cmp_count);
            if (num_errors == 0 && cmp_count > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            wr = 1'b1;
            addr = a;
            wdata = d;
            @(negedge clk);
            wr = 1'b0;
        end
    endtask
    task rreg(input [7:0] a, input [7:0] e);
        begin
            @(negedge clk);
            addr = a;
            @(negedge clk);
            check("reg", {24'h0, rdata}, {24'h0, e});
        end
    endtask
    function [31:0] xf(input [15:0] a, input [15:0] b);
        reg [15:0] x;
        reg [15:0] y;
        integer    j;
        begin
            for (j = 0; j < 16; j = j + 1) begin
                x[j] = a[cfg[5] ? j ^ (cfg[0] ? 7 : 15) : j];
                y[j] = b[cfg[5] ? j ^ (cfg[0] ? 7 : 15) : j];
            end
            x[15] = x[15] ^ cfg[7];
            y[15] = y[15] ^ cfg[7];
            xf = cfg[6] ? {y, x} : {x, y};
        end
    endfunction
    task push(input f);
        begin
            {ri, rq} = $random(seed);
            exp_q.push_back(xf(ri, rq));
            src.send(ri, rq, cfg[0], f);
        end
    endtask
    task drain;
        begin
            n = 0;
            while (exp_q.size() != 0 && n < 4000) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 4000) begin
                check("drain", 32'h1, 32'h0);
                summarize;
            end
        end
    endtask
    always @(negedge clk) begin
        if (vld === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("extra", 32'h1, 32'h0);
            end else begin
                check("sample", {si, sq}, exp_q.pop_front());
            end
        end
    end
    initial begin
        num_errors = 0;
        cmp_count = 0;
        seed = 32'hffdd9727;
        nrst = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        rdy = 1'b1;
        cfg = 8'h00;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        rreg(8'h26, 8'h00);
        rreg(8'h5e, 8'h00);
        rreg(8'h5f, 8'h00);
        rreg(8'h24, 8'h00);
        wreg(8'h10, 8'ha5);
        rreg(8'h10, 8'h00);
        wreg(8'h28, 8'h03);
        rreg(8'h28, 8'h03);
        wreg(8'h28, 8'h00);
        $display("test registers done");
        for (k = 0; k < 8; k = k + 1) begin
            cfg = {k[2:0], 5'h00};
            wreg(8'h26, cfg);
            wreg(8'h28, {6'h00, k[1:0]});
            push(1'b0);
            push(1'b0);
            drain;
        end
        $display("test word formats done");
        for (k = 0; k < 4; k = k + 1) begin
            wreg(8'h5e, k == 0 ? 8'h00 : k == 1 ? 8'h07 :
                k == 2 ? 8'h7f : 8'hff);
            wreg(8'h5f, k == 3 ? 8'h0d : 8'h08);
            rreg(8'h5f, k == 3 ? 8'h0d : 8'h08);
            push(1'b0);
            drain;
        end
        $display("test delay taps done");
        for (k = 0; k < 2; k = k + 1) begin
            cfg = k ? 8'he1 : 8'h01;
            wreg(8'h26, cfg);
            push(1'b1);
            push(1'b0);
            drain;
        end
        $display("test byte mode done");
        cfg = 8'h00;
        wreg(8'h26, cfg);
        wreg(8'h28, 8'h03);
        rdy = 1'b0;
        wreg(8'h06, 8'hff);
        rreg(8'h06, 8'h00);
        for (k = 0; k < 10; k = k + 1) begin
            push(1'b0);
            if (k == 8) tmp = exp_q.pop_back();
        end
        rreg(8'h24, 8'h08);
        rreg(8'h06, 8'h06);
        rdy = 1'b1;
        drain;
        rreg(8'h24, 8'h00);
        repeat (16) @(negedge clk);
        rreg(8'h06, 8'h07);
        rdy = 1'b0;
        wreg(8'h06, 8'h02);
        rreg(8'h06, 8'h05);
        $display("test fifo fill done");
        summarize;
    end
endmodule // lsif_rx_test
